// [dv/mtc_phy_model.sv]
`timescale 1ns/1ps
module mtc_phy_model (
	// Clock and script
	input wire logic clk,
	input wire logic clr,
	input wire logic [15:0] colAt,
	input wire logic [7:0] colHits,
	// Wire from the MAC
	input wire logic phyTxEn,
	input wire logic phyTxEr,
	// Collision back
	output logic phyCol,
	// Seen on the wire
	output logic [15:0] dataCnt,
	output logic [15:0] extCnt,
	output logic [7:0] tries
);
	logic act = 1'h0;
	initial begin
		dataCnt = 16'h0;
		extCnt = 16'h0;
		tries = 8'h0;
	end
	// Collision lasts one byte time; never on the first byte, old count is stale then
	assign phyCol = phyTxEn && act && dataCnt == colAt && tries <= colHits;
	always @(posedge clk) begin
		act <= phyTxEn || phyTxEr;
		if (clr) begin
			tries <= 8'h0;
		end else if (phyTxEn && !act) begin
			dataCnt <= 16'h1;
			extCnt <= 16'h0;
			tries <= tries + 8'h1;
		end else begin
			dataCnt <= dataCnt + 16'(phyTxEn);
			extCnt <= extCnt + 16'(phyTxEr);
		end
	end
endmodule : mtc_phy_model

// [dv/mtc_tx_control_checker.sv]
`timescale 1ns/1ps
module mtc_tx_control_checker (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Register bus
	input wire logic [11:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// Frame and wire
	input wire logic frmValid,
	input wire logic txReady,
	input wire logic frmDone,
	input wire logic frmAbort,
	input wire logic linkGig,
	input wire logic [7:0] phyTxd,
	input wire logic phyTxEn,
	input wire logic phyTxEr,
	// Read path
	input wire logic rdWant,
	input wire logic rdReqValid,
	input wire logic reqStaged,
	input wire logic pbRead
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////
	sequence busReq;
		$rose(avs_read || avs_write);
	endsequence
	sequence oneWait;
		avs_waitrequest ##1 !avs_waitrequest;
	endsequence
	one_wait_a: assert property (busReq |-> oneWait) else $error("bus wait not one cycle");
	rsv_zero_a: assert property (avs_read && !avs_waitrequest && avs_address == 12'h400
		|-> (avs_readdata & 32'h80000005) == 32'h0) else $error("reserved bit reads one");
	tx_start_a: assert property (txReady && frmValid |-> ##2 phyTxEn)
		else $error("frame start late");
	end_pulse_a: assert property (frmDone |=> !frmDone && !frmAbort)
		else $error("end pulse too long");
	ext_sym_a: assert property (phyTxEr |-> !phyTxEn && phyTxd == 8'h0f)
		else $error("bad extension symbol");
	slow_noext_a: assert property (!linkGig |-> !phyTxEr)
		else $error("extension on slow link");
	rd_gate_a: assert property (rdReqValid |-> rdWant) else $error("unwanted read");
	stage_rd_a: assert property (reqStaged |=> pbRead) else $error("no buffer read");
endmodule : mtc_tx_control_checker

// [dv/mtc_tx_control_tb_top.sv]
`timescale 1ns/1ps
module mtc_tx_control_tb_top;
	typedef struct {logic [15:0] len; logic [31:0] ctl; logic gig; logic [15:0] d, e;} mtc_row_t;
	logic clk = 1'h0, sys_rst = 1'h1, avs_read = 1'h0, avs_write = 1'h0, nvmLoad = 1'h0;
	logic nvmMultiRead = 1'h0, frmValid = 1'h0, linkGig = 1'h0, fullDuplex = 1'h1, rdWant = 1'h0;
	logic rdReqReady = 1'h1, rdCpl = 1'h0, lineIn = 1'h0, reqStaged = 1'h0, clr = 1'h0, ab;
	logic [3:0] avs_byteenable = 4'hf;
	logic [11:0] avs_address = 12'h0;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
	logic [15:0] frmLen = 16'h0, pauseTime = 16'h1234, colAt = 16'h0, frmIdx, dataCnt, extCnt;
	logic [7:0] colHits = 8'h0, frmByte, phyTxd, tries;
	logic avs_waitrequest, txReady, frmDone, frmAbort, phyTxEn, phyTxEr, phyCol, rdReqValid, pbRead;
	int err_total = 0, checked = 0, nReq = 0;
	mtc_row_t rows[5] = '{'{16'h14, 32'ha, 1'h0, 16'h40, 16'h0}, '{16'h14, 32'h2, 1'h0, 16'h14, 16'h0},
		'{16'h64, 32'ha, 1'h0, 16'h64, 16'h0}, '{16'h14, 32'h63002, 1'h1, 16'h14, 16'h50},
		'{16'h14, 32'h63002, 1'h0, 16'h14, 16'h0}};
	assign frmByte = frmIdx[7:0];
	initial forever #4 clk = ~clk;
	always @(posedge clk) if (rdReqValid && rdReqReady) nReq <= nReq + 1;
	mtc_tx_control u_mtc_tx_control (.*);
	mtc_phy_model u_mtc_phy_model (.*);
	////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		do begin
			@(posedge clk);
		end while (avs_waitrequest);
		q = avs_readdata;
		avs_read <= 1'h0;
		avs_write <= 1'h0;
	endtask : bus
	task automatic start(input logic [15:0] len);
		@(posedge clk);
		clr <= 1'h1;
		frmValid <= 1'h1;
		frmLen <= len;
		@(posedge clk);
		clr <= 1'h0;
	endtask : start
	task automatic fin();
		int t = 0;
		do begin
			@(posedge clk);
			t++;
		end while (!frmDone && !frmAbort && t < 20000);
		ab = frmAbort;
		frmValid <= 1'h0;
		if (t >= 20000) err_total++;
		repeat (2) @(posedge clk);
	endtask : fin
	task automatic frame(input logic [15:0] len);
		start(len);
		fin();
		frmValid <= 1'h0;
	endtask : frame
	task automatic col(input logic [31:0] c, input logic [15:0] at, input logic [7:0] h,
		input logic ea, input logic [7:0] et);
		bus(1'h1, 12'h400, c);
		colAt <= at;
		colHits <= h;
		frame(16'h50);
		chk("abort", ea, ab);
		chk("attempts", et, tries);
	endtask : col
	task automatic summarize();
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : summarize
	////////////////////////////////////////
	initial begin
		#400000;
		err_total++;
		summarize();
	end
	initial begin
		int t;
		repeat (2) @(posedge clk);
		sys_rst <= 1'h0;
		bus(1'h0, 12'h400, 32'h0);
		chk("ctrl reset", 32'h30000008, q);
		bus(1'h1, 12'h400, 32'hff3fffff);
		bus(1'h0, 12'h400, 32'h0);
		chk("ctrl mask", 32'h7f3ffffa, q);
		bus(1'h0, 12'h408, 32'h0);
		chk("unmapped", 32'h0, q);
		nvmLoad <= 1'h1;
		@(posedge clk);
		nvmLoad <= 1'h0;
		bus(1'h0, 12'h400, 32'h0);
		chk("nvm load", 32'h6f3ffffa, q);
		foreach (rows[i]) begin
			bus(1'h1, 12'h400, rows[i].ctl);
			linkGig <= rows[i].gig;
			frame(rows[i].len);
			chk("data bytes", rows[i].d, dataCnt);
			chk("ext symbols", rows[i].e, extCnt);
		end
		bus(1'h1, 12'h400, 32'hf2);
		bus(1'h0, 12'h400, 32'h0);
		chk("threshold fifteen", 32'hf2, q);
		// Half duplex at slow speed: window is 64 bytes
		linkGig <= 1'h0;
		fullDuplex <= 1'h0;
		col(32'h22, 16'h5, 8'hff, 1'h1, 8'h3);
		col(32'h2, 16'h46, 8'hff, 1'h0, 8'h1);
		col(32'h1000022, 16'h46, 8'h1, 1'h0, 8'h2);
		fullDuplex <= 1'h1;
		col(32'h1000022, 16'h5, 8'hff, 1'h0, 8'h1);
		colHits <= 8'h0;
		bus(1'h1, 12'h400, 32'h8);
		start(16'h64);
		repeat (30) @(posedge clk);
		chk("sent while off", 32'h0, tries);
		bus(1'h1, 12'h400, 32'ha);
		bus(1'h1, 12'h400, 32'h8);
		fin();
		chk("frame finished", 32'h64, dataCnt);
		frmValid <= 1'h1;
		repeat (20) @(posedge clk);
		chk("no restart", 32'h1, tries);
		frmValid <= 1'h0;
		// Pause only in full duplex, as software must
		clr <= 1'h1;
		bus(1'h1, 12'h400, 32'h400002);
		clr <= 1'h0;
		q[22] = 1'h1;
		for (int i = 0; i < 60 && q[22]; i++) bus(1'h0, 12'h400, 32'h0);
		chk("pause cleared", 32'h0, q[22]);
		chk("pause length", 32'h3c, dataCnt);
		for (int m = 0; m < 2; m++) begin
			bus(1'h1, 12'h400, {3'h0, m[0], 28'h2});
			nReq = 0;
			rdWant <= 1'h1;
			repeat (10) @(posedge clk);
			rdWant <= 1'h0;
			@(posedge clk);
			chk("read requests", m ? 4 : 1, nReq);
			rdCpl <= 1'h1;
			repeat (m ? 4 : 1) @(posedge clk);
			rdCpl <= 1'h0;
		end
		for (int i = 0; i < 4; i++) begin
			bus(1'h1, 12'h400, {1'h0, i[1:0], 29'h2});
			repeat (i < 3 ? 2 << i : 1) begin
				lineIn <= i < 3;
				reqStaged <= i == 3;
				@(posedge clk);
				lineIn <= 1'h0;
				reqStaged <= 1'h0;
				@(posedge clk);
			end
			t = 0;
			while (!pbRead && t < 9) begin
				@(posedge clk);
				t++;
			end
			chk("buffer read", 32'h1, pbRead);
		end
		sys_rst <= 1'h1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'h0;
		bus(1'h0, 12'h400, 32'h0);
		chk("ctrl second reset", 32'h30000008, q);
		summarize();
	end
endmodule : mtc_tx_control_tb_top
bind mtc_tx_control mtc_tx_control_checker u_chk (.*);

// [rtl/mtc_pkg.sv]
package mtc_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_XMIT, ST_BACKOFF} mtc_state_t;
	typedef struct packed {
		logic [31:0] ctrl;
		logic ack;
		logic [31:0] rdData;
		mtc_state_t st;
		logic [15:0] idx;
		logic [15:0] len;
		logic pause;
		logic [7:0] retries;
		logic [9:0] slots;
		logic [9:0] slotCnt;
		logic [15:0] lfsr;
		logic [7:0] txData;
		logic txEn;
		logic txEr;
		logic done;
		logic abort;
	} mtc_tx_t;
	typedef struct packed {
		logic [2:0] outst;
		logic [3:0] lines;
		logic pbRead;
	} mtc_rd_t;
endpackage : mtc_pkg

// [rtl/mtc_rd_if.sv]
`timescale 1ns/1ps
interface mtc_rd_if;
	logic multi;
	logic [1:0] level;
	logic want;
	logic reqValid;
	logic reqReady;
	logic cpl;
	logic lineIn;
	logic staged;
	logic pbRead;
	modport dev (input multi, level, want, reqReady, cpl, lineIn, staged,
		output reqValid, pbRead);
	modport ctl (output multi, level, want, reqReady, cpl, lineIn, staged,
		input reqValid, pbRead);
endinterface : mtc_rd_if

// [rtl/mtc_read_ctl.sv]
`timescale 1ns/1ps
`include "mtc_regs.svh"
module mtc_read_ctl #(
	parameter int MAX_OUT = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Read path toward host and packet buffer
	mtc_rd_if.dev rd
);
	import mtc_pkg::*;

	if (MAX_OUT < 1 || MAX_OUT > 7) begin : g_chk
		$error("MAX_OUT must lie in 1..7");
	end

	mtc_rd_t s_r;
	mtc_rd_t s_nxt;
	logic [2:0] limit;
	logic [3:0] thr;
	logic fire;

	always_comb begin
		limit = rd.multi ? 3'(MAX_OUT) : 3'h1;
		case (rd.level)
			2'h0: thr = `MTC_LINES_L0;
			2'h1: thr = `MTC_LINES_L1;
			2'h2: thr = `MTC_LINES_L2;
			default: thr = 4'hf;
		endcase
	end

	assign rd.reqValid = rd.want && (s_r.outst < limit);
	assign rd.pbRead = s_r.pbRead;
	// Whole-request mode waits only for the staged marker
	assign fire = rd.staged || (rd.level != `MTC_LVL_WHOLE && s_r.lines >= thr);

	always_comb begin
		s_nxt = s_r;
		s_nxt.pbRead = fire;
		s_nxt.outst = s_r.outst + 3'(rd.reqValid && rd.reqReady) - 3'(rd.cpl && s_r.outst != 3'h0);
		if (fire) begin
			s_nxt.lines = 4'h0;
		end else if (rd.lineIn && s_r.lines != 4'hf) begin
			s_nxt.lines = s_r.lines + 4'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule : mtc_read_ctl

// [rtl/mtc_regs.svh]
`ifndef MTC_REGS_SVH
`define MTC_REGS_SVH
// Register byte offsets
`define MTC_OFS_CTRL 12'h400
`define MTC_OFS_STAT 12'h404
// Control register layout
`define MTC_EN_BIT 1
`define MTC_PAD_BIT 3
`define MTC_THR_LSB 4
`define MTC_THR_MSB 11
`define MTC_DIST_LSB 12
`define MTC_DIST_MSB 21
`define MTC_PAUSE_BIT 22
`define MTC_BURST_BIT 23
`define MTC_LATE_BIT 24
`define MTC_MULTI_BIT 28
`define MTC_LVL_LSB 29
`define MTC_LVL_MSB 30
`define MTC_CTRL_RST 32'h30000008
`define MTC_CTRL_WMASK 32'h7ffffffa
// Frame and slot sizes in byte times
`define MTC_MIN_FRAME 16'h0040
`define MTC_WIN_SLOW 16'h0040
`define MTC_WIN_GIG 16'h0200
`define MTC_BACKOFF_CAP 8'h0a
`define MTC_SLOT_MASK 10'h3ff
`define MTC_EXT_SYM 8'h0f
`define MTC_PAD_BYTE 8'h00
// Pause frame: 60 bytes before FCS, header then timer
`define MTC_PAUSE_LEN 16'h003c
`define MTC_PAUSE_HDR 128'h0180c2000001_000000000000_8808_0001
`define MTC_PAUSE_HDR_LEN 16'h0010
// Read staging levels in 16-byte lines
`define MTC_LINES_L0 4'h2
`define MTC_LINES_L1 4'h4
`define MTC_LINES_L2 4'h8
`define MTC_LVL_WHOLE 2'h3
`endif

// [rtl/mtc_tx_control.sv]
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "mtc_regs.svh"
////////////////////////////////////////////////////////////////////////////////
// How it works
// - Frames start only while enable bit set; pause ignores it
// - Disable finishes current frame, then stops
// - Pad bit pads short frames to 64
// - Half duplex: retries capped by threshold field
// - Exponential back-off range stops after ten
// - Extension symbols up to distance plus one
// - No extension symbols at slower speeds
// - Pause request sends XOFF, then self-clears
// - Pause request not gated by duplex
// - Late collision retry bit, half duplex only
// - Late beyond 64 or 512 byte window
// - One read request, or four when multi
// - Multi-read bit loaded from nonvolatile memory
// - Packet buffer read at staging level
// - Reserved bits read back as zero
module mtc_tx_control #(
	parameter int MAX_OUT = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Avalon-MM register slave
	input wire logic [11:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Nonvolatile memory load
	input wire logic nvmLoad,
	input wire logic nvmMultiRead,
	// Frame source
	input wire logic frmValid,
	input wire logic [15:0] frmLen,
	input wire logic [7:0] frmByte,
	output logic [15:0] frmIdx,
	output logic txReady,
	output logic frmDone,
	output logic frmAbort,
	input wire logic [15:0] pauseTime,
	// PHY side
	input wire logic linkGig,
	input wire logic fullDuplex,
	input wire logic phyCol,
	output logic [7:0] phyTxd,
	output logic phyTxEn,
	output logic phyTxEr,
	// Host read and packet buffer
	input wire logic rdWant,
	output logic rdReqValid,
	input wire logic rdReqReady,
	input wire logic rdCpl,
	input wire logic lineIn,
	input wire logic reqStaged,
	output logic pbRead
);
	import mtc_pkg::*;

	if (MAX_OUT < 1 || MAX_OUT > 7) begin : g_chk
		$error("MAX_OUT must lie in 1..7");
	end

	mtc_tx_t s_r;
	mtc_tx_t s_nxt;
	mtc_rd_if rdBus();
	// A literal cannot be part-selected, so the header bytes live in a constant
	localparam logic [127:0] PauseHdr = `MTC_PAUSE_HDR;

	////////////////////////////////////////////////////////////////////////////
	// Read request side
	assign rdBus.multi = s_r.ctrl[`MTC_MULTI_BIT];
	assign rdBus.level = s_r.ctrl[`MTC_LVL_MSB:`MTC_LVL_LSB];
	assign rdBus.want = rdWant;
	assign rdBus.reqReady = rdReqReady;
	assign rdBus.cpl = rdCpl;
	assign rdBus.lineIn = lineIn;
	assign rdBus.staged = reqStaged;
	assign rdReqValid = rdBus.reqValid;
	assign pbRead = rdBus.pbRead;

	mtc_read_ctl #(
		.MAX_OUT(MAX_OUT)
	) u_read (
		.clk(clk),
		.sys_rst(sys_rst),
		.rd(rdBus)
	);

	////////////////////////////////////////////////////////////////////////////
	// Control fields
	logic enBit;
	logic padBit;
	logic lateRetry;
	logic [7:0] collThr;
	logic [9:0] collDist;
	assign enBit = s_r.ctrl[`MTC_EN_BIT];
	assign padBit = s_r.ctrl[`MTC_PAD_BIT];
	assign lateRetry = s_r.ctrl[`MTC_LATE_BIT];
	assign collThr = s_r.ctrl[`MTC_THR_MSB:`MTC_THR_LSB];
	assign collDist = s_r.ctrl[`MTC_DIST_MSB:`MTC_DIST_LSB];

	////////////////////////////////////////////////////////////////////////////
	// Byte kind for the current index
	logic [15:0] dataEnd;
	logic [15:0] extEnd;
	logic [15:0] window;
	logic [15:0] slotLen;
	logic inData;
	logic inPad;
	logic inExt;
	logic [7:0] pauseByte;
	logic [7:0] dataByte;
	logic halfCol;
	logic lateCol;

	always_comb begin
		dataEnd = (padBit && s_r.len < `MTC_MIN_FRAME) ? `MTC_MIN_FRAME : s_r.len;
		extEnd = 16'(collDist) + 16'h1;
		window = linkGig ? `MTC_WIN_GIG : `MTC_WIN_SLOW;
		slotLen = linkGig ? `MTC_WIN_GIG : `MTC_WIN_SLOW;
		inData = s_r.idx < s_r.len;
		inPad = !inData && s_r.idx < dataEnd;
		// Extension only on a gigabit link; slower links never see it
		inExt = !inData && !inPad && linkGig && s_r.idx < extEnd;
		// Source address left zero; the sending MAC is expected to patch it
		if (s_r.idx < `MTC_PAUSE_HDR_LEN) begin
			pauseByte = PauseHdr[8'(8'h7f - 8'(s_r.idx[3:0]) * 8'h8) -: 8];
		end else if (s_r.idx == `MTC_PAUSE_HDR_LEN) begin
			pauseByte = pauseTime[15:8];
		end else if (s_r.idx == `MTC_PAUSE_HDR_LEN + 16'h1) begin
			pauseByte = pauseTime[7:0];
		end else begin
			pauseByte = `MTC_PAD_BYTE;
		end
		dataByte = s_r.pause ? pauseByte : frmByte;
		halfCol = phyCol && !fullDuplex;
		lateCol = s_r.idx >= window;
	end

	////////////////////////////////////////////////////////////////////////////
	// Back-off range
	logic [7:0] nextTry;
	logic [3:0] rangeBits;
	logic [9:0] rangeMask;

	always_comb begin
		nextTry = s_r.retries + 8'h1;
		// Range growth stops at ten doublings
		rangeBits = (nextTry > `MTC_BACKOFF_CAP) ? 4'(`MTC_BACKOFF_CAP) : nextTry[3:0];
		rangeMask = `MTC_SLOT_MASK >> (4'ha - rangeBits);
	end

	////////////////////////////////////////////////////////////////////////////
	// Register bus
	logic busReq;
	logic hitCtrl;
	logic hitStat;
	logic [31:0] regRead;
	logic [31:0] wrMerge;

	assign busReq = avs_read || avs_write;
	assign hitCtrl = avs_address == `MTC_OFS_CTRL;
	assign hitStat = avs_address == `MTC_OFS_STAT;
	// First cycle of a request always stalls; answer lands on the second
	assign avs_waitrequest = busReq && !s_r.ack;
	assign avs_readdata = s_r.rdData;

	always_comb begin
		if (hitCtrl) begin
			regRead = s_r.ctrl & `MTC_CTRL_WMASK;
		end else if (hitStat) begin
			regRead = {s_r.idx, s_r.retries, 5'h0, enBit, 2'(s_r.st)};
		end else begin
			regRead = 32'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		s_nxt.abort = 1'b0;
		s_nxt.txEn = 1'b0;
		s_nxt.txEr = 1'b0;
		s_nxt.txData = 8'h0;
		s_nxt.lfsr = {s_r.lfsr[14:0], s_r.lfsr[15] ^ s_r.lfsr[13] ^ s_r.lfsr[12] ^ s_r.lfsr[10]};
		s_nxt.ack = busReq && !s_r.ack;
		if (busReq && !s_r.ack) begin
			s_nxt.rdData = regRead;
		end

		case (s_r.st)
			ST_IDLE: begin
				s_nxt.idx = 16'h0;
				s_nxt.retries = 8'h0;
				// Pause request ignores duplex and the enable bit
				if (s_r.ctrl[`MTC_PAUSE_BIT]) begin
					s_nxt.pause = 1'b1;
					s_nxt.len = `MTC_PAUSE_LEN;
					s_nxt.st = ST_XMIT;
				// Source still shows the finished frame while its end pulse stands
				end else if (enBit && frmValid && !s_r.done && !s_r.abort) begin
					s_nxt.pause = 1'b0;
					s_nxt.len = frmLen;
					s_nxt.st = ST_XMIT;
				end
			end
			ST_XMIT: begin
				// Collision before the window, or late with retry on
				if (halfCol && (!lateCol || lateRetry)) begin
					s_nxt.idx = 16'h0;
					if (s_r.retries >= collThr) begin
						s_nxt.abort = !s_r.pause;
						s_nxt.st = ST_IDLE;
						if (s_r.pause) begin
							s_nxt.ctrl[`MTC_PAUSE_BIT] = 1'b0;
						end
					end else begin
						s_nxt.retries = nextTry;
						s_nxt.slots = s_r.lfsr[9:0] & rangeMask;
						s_nxt.slotCnt = 10'h0;
						s_nxt.st = ST_BACKOFF;
					end
				end else if (inData || inPad) begin
					// A late collision with retry off is simply ridden out
					s_nxt.txEn = 1'b1;
					s_nxt.txData = inData ? dataByte : `MTC_PAD_BYTE;
					s_nxt.idx = s_r.idx + 16'h1;
				end else if (inExt) begin
					s_nxt.txEr = 1'b1;
					s_nxt.txData = `MTC_EXT_SYM;
					s_nxt.idx = s_r.idx + 16'h1;
				end else begin
					// Frame complete; enable is looked at again only in idle
					s_nxt.st = ST_IDLE;
					if (s_r.pause) begin
						s_nxt.ctrl[`MTC_PAUSE_BIT] = 1'b0;
					end else begin
						s_nxt.done = 1'b1;
					end
				end
			end
			ST_BACKOFF: begin
				// No jam is sent; the PHY side owns jamming
				if (s_r.slots == 10'h0) begin
					s_nxt.st = ST_XMIT;
				end else if (16'(s_r.slotCnt) == slotLen - 16'h1) begin
					s_nxt.slotCnt = 10'h0;
					s_nxt.slots = s_r.slots - 10'h1;
				end else begin
					s_nxt.slotCnt = s_r.slotCnt + 10'h1;
				end
			end
			default: begin
				s_nxt.st = ST_IDLE;
			end
		endcase

		// Software write lands after the hardware clear, so a set wins
		wrMerge = s_nxt.ctrl;
		for (int b = 0; b < 4; b++) begin
			if (avs_byteenable[b]) begin
				wrMerge[8 * b +: 8] = avs_writedata[8 * b +: 8];
			end
		end
		if (avs_write && s_r.ack && hitCtrl) begin
			s_nxt.ctrl = wrMerge & `MTC_CTRL_WMASK;
		end
		if (nvmLoad) begin
			s_nxt.ctrl[`MTC_MULTI_BIT] = nvmMultiRead;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_r <= '0;
			s_r.ctrl <= `MTC_CTRL_RST;
			s_r.lfsr <= 16'hace1;
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	// Frames wait at the source while disabled; only reset discards them
	assign txReady = enBit && s_r.st == ST_IDLE && !s_r.ctrl[`MTC_PAUSE_BIT]
		&& !s_r.done && !s_r.abort;
	assign frmIdx = s_r.idx;
	assign frmDone = s_r.done;
	assign frmAbort = s_r.abort;
	assign phyTxd = s_r.txData;
	assign phyTxEn = s_r.txEn;
	assign phyTxEr = s_r.txEr;
endmodule : mtc_tx_control
